// ---- rtl/act_clock_tree.sv ----
// Audio clock tree configuration: register file, source selection and four clock dividers.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Core source field selects core divider input.
// - Converter source codes pick master, PLL, oscillator, pins.
// - Oversample source codes add converter clock first.
// - Pump source uses oversample encoding; others mute.
// - Core pin pick: 011 pin zero, 101 two.
// - Converter pin pick: 011 pin zero, 101 two.
// - Pump pin pick: 011 pin zero, 101 two.
// - Oversample pin pick: 011 pin zero, 101 two.
// - PLL reference pin pick: 011 zero, 101 two.
// - Pre-divider P is code plus one; 1111 forbidden.
// - Multiplier J equals code; zero forbidden.
// - Fraction D from two registers, at most 9999.
// - PLL multiplies by J.D times R, R code plus one.
// - Auto-set mode overrides PLL factors and ratios.
// - Core divider divides by code plus one.
// - Converter divider divides by code plus one.
// - Pump divider divides by code plus one.
// - Oversample divider divides by code plus one.
// - Auto-set disable bit: zero on, reset zero.
// - PLL off switches PLL clock, and master clock when present, to master pin.
module act_clock_tree
    import act_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [8:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [8:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pll_clk,
    input wire logic internal_oscillator,
    input wire logic master_clock_pin,
    input wire logic bit_clock,
    input wire logic general_pin_zero,
    input wire logic general_pin_two,
    input wire logic master_present,
    output logic core_clk,
    output logic converter_clk,
    output logic pump_clk,
    output logic oversample_clk,
    output logic pll_ref_pin_clk,
    output logic [4:0] pll_p,
    output logic [5:0] pll_j,
    output logic [13:0] pll_d,
    output logic [4:0] pll_r,
    output logic pll_enable
);
    function automatic logic [4:0] slot_of(input logic [8:0] addr);
        logic [4:0] s;
        s = ACT_SLOT_NONE;
        for (int k = 0; k < ACT_NREG; k++) begin
            if (addr[8:2] == ACT_REG_IDX[k]) begin
                s = 5'(k);
            end
        end
        return s;
    endfunction

    function automatic logic pin_pick(input logic [2:0] code, input logic p0, input logic p2);
        logic v;
        v = 1'b0;
        if (code == PIN_ZERO_CODE) begin
            v = p0;
        end else if (code == PIN_TWO_CODE) begin
            v = p2;
        end
        return v;
    endfunction

    // Converter-style codes skip the converter-clock slot of the source vector.
    function automatic logic [2:0] conv_idx(input logic [2:0] code);
        return (code <= CONV_LAST_CODE) ? 3'(code + 3'h1) : SRC_MUTE_IDX;
    endfunction

    function automatic logic src_pick(input logic [6:0] v, input logic [2:0] idx);
        return (idx == SRC_MUTE_IDX) ? 1'b0 : v[idx];
    endfunction

    logic [7:0] cfg_r [ACT_NREG];
    logic aw_held_r;
    logic w_held_r;
    logic [4:0] wslot_r;
    logic [7:0] wbyte_r;
    logic wlane_r;
    logic wr_go;
    logic [4:0] rslot;
    logic [7:0] status;
    logic auto_on;
    logic pll_lvl;
    logic master_lvl;
    logic [2:0] sel_idx [4];
    logic [6:0] src_vec [4];
    logic src_lvl [4];
    logic [6:0] ratio [4];
    logic [6:0] cnt_r [4];
    logic prev_r [4];
    logic div_r [4];

    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign rslot = slot_of(s_axi_araddr);
    assign auto_on = !cfg_r[S_AUTO_CTL][POS_AUTO_DIS];

    // Write channel: address and data may arrive in either order, response follows both.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            wslot_r <= ACT_SLOT_NONE;
            wbyte_r <= 8'h00;
            wlane_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                s_axi_awready <= 1'b0;
                wslot_r <= slot_of(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                s_axi_wready <= 1'b0;
                wbyte_r <= s_axi_wdata[7:0];
                wlane_r <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wslot_r == ACT_SLOT_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Configuration storage. Forbidden P, J and D codes are kept as written; the far side
    // must not write them, so no clamping is spent here.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < ACT_NREG; k++) begin
                cfg_r[k] <= ACT_REG_RST[k];
            end
        end else if (wr_go && wlane_r && wslot_r != ACT_SLOT_NONE) begin
            cfg_r[wslot_r] <= wbyte_r & ACT_REG_MASK[wslot_r];
        end
    end

    // Read channel: one cycle from address to data.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                if (rslot == ACT_SLOT_NONE) begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end else begin
                    s_axi_rdata <= {24'h000000, (rslot == 5'(S_STATUS)) ? status : cfg_r[rslot]};
                    s_axi_rresp <= RESP_OKAY;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Source vectors, index 0 is the converter clock for pump and oversample (tied low for core and converter), 1 the auto-selected master.
    always_comb begin
        pll_lvl = cfg_r[S_PLL_CTL][POS_PLL_ON] ? pll_clk : master_clock_pin;
        master_lvl = master_present ? pll_lvl : internal_oscillator;
        src_vec[0] = {pin_pick(cfg_r[S_PIN_CC][6:4], general_pin_zero, general_pin_two),
            bit_clock, master_clock_pin, internal_oscillator, pll_lvl, master_lvl, 1'b0};
        src_vec[1] = {pin_pick(cfg_r[S_PIN_CC][2:0], general_pin_zero, general_pin_two),
            bit_clock, master_clock_pin, internal_oscillator, pll_lvl, master_lvl, 1'b0};
        src_vec[2] = {pin_pick(cfg_r[S_PIN_PO][6:4], general_pin_zero, general_pin_two),
            bit_clock, master_clock_pin, internal_oscillator, pll_lvl, master_lvl, div_r[1]};
        src_vec[3] = {pin_pick(cfg_r[S_PIN_PO][2:0], general_pin_zero, general_pin_two),
            bit_clock, master_clock_pin, internal_oscillator, pll_lvl, master_lvl, div_r[1]};
        sel_idx[0] = conv_idx(cfg_r[S_CORE_SRC][2:0]);
        sel_idx[1] = conv_idx(cfg_r[S_CONV_OVS][6:4]);
        sel_idx[2] = cfg_r[S_PUMP_SRC][2:0];
        sel_idx[3] = cfg_r[S_CONV_OVS][2:0];
        for (int i = 0; i < 4; i++) begin
            src_lvl[i] = src_pick(src_vec[i], sel_idx[i]);
            ratio[i] = auto_on ? AUTO_RATIO[i] : cfg_r[S_DIV0 + i][6:0];
        end
    end

    // Dividers count rising edges of the sampled source. Ratio changes take effect at once; a count already at or
    // above the new limit wraps on the next edge, so that period is cut short, hence the idle-only advice.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 4; i++) begin
                cnt_r[i] <= 7'h00;
                prev_r[i] <= 1'b0;
                div_r[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                prev_r[i] <= src_lvl[i];
                if (sel_idx[i] == SRC_MUTE_IDX) begin
                    cnt_r[i] <= 7'h00;
                    div_r[i] <= 1'b0;
                end else if (ratio[i] == 7'h00) begin
                    cnt_r[i] <= 7'h00;
                    div_r[i] <= src_lvl[i];
                end else if (src_lvl[i] && !prev_r[i]) begin
                    if (cnt_r[i] >= ratio[i]) begin
                        cnt_r[i] <= 7'h00;
                        div_r[i] <= 1'b1;
                    end else begin
                        cnt_r[i] <= cnt_r[i] + 7'h01;
                        div_r[i] <= (8'({1'b0, cnt_r[i]}) + 8'h01) < ((8'({1'b0, ratio[i]}) + 8'h02) >> 1);
                    end
                end
            end
        end
    end

    assign core_clk = div_r[0];
    assign converter_clk = div_r[1];
    assign pump_clk = div_r[2];
    assign oversample_clk = div_r[3];

    // PLL factors handed to the analog PLL; auto mode substitutes its own set.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_p <= 5'h01;
            pll_j <= AUTO_J;
            pll_d <= AUTO_D;
            pll_r <= 5'h01;
            pll_enable <= ACT_REG_RST[S_PLL_CTL][POS_PLL_ON];
            pll_ref_pin_clk <= 1'b0;
        end else begin
            pll_enable <= cfg_r[S_PLL_CTL][POS_PLL_ON];
            pll_ref_pin_clk <= pin_pick(cfg_r[S_PIN_REF][2:0], general_pin_zero, general_pin_two);
            if (auto_on) begin
                pll_p <= 5'({1'b0, AUTO_P_CODE} + 5'h01);
                pll_j <= AUTO_J;
                pll_d <= AUTO_D;
                pll_r <= 5'({1'b0, AUTO_R_CODE} + 5'h01);
            end else begin
                pll_p <= 5'({1'b0, cfg_r[S_PLL_P][6:3]} + 5'h01);
                pll_j <= cfg_r[S_PLL_J][5:0];
                pll_d <= {cfg_r[S_PLL_DH][5:0], cfg_r[S_PLL_DL]};
                pll_r <= 5'({1'b0, cfg_r[S_PLL_R][3:0]} + 5'h01);
            end
        end
    end

    always_comb begin
        status = 8'h00;
        for (int i = 0; i < 4; i++) begin
            status[i] = (sel_idx[i] == SRC_MUTE_IDX);
        end
        status[4] = !master_present;
    end

    a_conv_mute: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_r[S_CONV_OVS][6:4] > 3'h5 |=> !converter_clk) else $error("muted converter clock toggles");
    a_conv_mclk: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_r[S_CONV_OVS][6:4] == 3'h3 && ratio[1] == 7'h00 |=> converter_clk == $past(master_clock_pin))
        else $error("converter clock not master pin");
    a_ovs_conv: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_r[S_CONV_OVS][2:0] == 3'h0 && ratio[3] == 7'h00 |=> oversample_clk == $past(converter_clk))
        else $error("oversample clock not converter clock");
    a_pump_mute: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_r[S_PUMP_SRC][2:0] == 3'h7 |=> !pump_clk) else $error("muted pump clock toggles");
    a_core_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_r[S_CORE_SRC][2:0] == 3'h5 && cfg_r[S_PIN_CC][6:4] == 3'h5 && ratio[0] == 7'h00
        |=> core_clk == $past(general_pin_two)) else $error("core pin pick wrong");
    a_ref_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_r[S_PIN_REF][2:0] == 3'h3 |=> pll_ref_pin_clk == $past(general_pin_zero))
        else $error("reference pin pick wrong");
    a_pll_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !cfg_r[S_PLL_CTL][POS_PLL_ON] && cfg_r[S_CONV_OVS][6:4] == 3'h1 && ratio[1] == 7'h00
        |=> converter_clk == $past(master_clock_pin)) else $error("PLL off not on master pin");
    a_manual_p: assert property (@(posedge aclk) disable iff (!aresetn)
        !auto_on ##1 !auto_on |-> pll_p == 5'({1'b0, $past(cfg_r[S_PLL_P][6:3])} + 5'h01))
        else $error("P not code plus one");
    a_auto_ovr: assert property (@(posedge aclk) disable iff (!aresetn)
        auto_on |=> pll_j == AUTO_J && pll_r == 5'h01) else $error("auto mode ignored");
    a_div_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        ratio[2] != 7'h00 && $stable(ratio[2]) && $past(cnt_r[2]) <= ratio[2] |-> cnt_r[2] <= ratio[2])
        else $error("pump count overrun");
    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> s_axi_bvalid ##0 !s_axi_awready) else $error("write not answered");
    c_div_wrap: cover property (@(posedge aclk) disable iff (!aresetn) !auto_on && cnt_r[1] == 7'h7f);
    c_pin_clock: cover property (@(posedge aclk) disable iff (!aresetn) sel_idx[3] == 3'h6 && oversample_clk);
    c_read_status: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && rslot == 5'(S_STATUS));
endmodule
`default_nettype wire

// ---- rtl/act_pkg.sv ----
// Package with the register map, reset values and fixed settings of the audio clock tree.
package act_pkg;
    localparam int ACT_NREG = 19;
    localparam logic [4:0] ACT_SLOT_NONE = 5'h1f;
    // Slot order: core source, conv/ovs source, pump source, three pin picks rows, PLL factors,
    // four divider ratios, bit clock ratio, PLL control, auto-set control, status.
    localparam logic [6:0] ACT_REG_IDX [ACT_NREG] = '{
        7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11, 7'h12, 7'h14, 7'h15, 7'h16, 7'h17,
        7'h18, 7'h1b, 7'h1c, 7'h1d, 7'h1e, 7'h20, 7'h04, 7'h25, 7'h40};
    localparam logic [7:0] ACT_REG_MASK [ACT_NREG] = '{
        8'h07, 8'h77, 8'h07, 8'h77, 8'h77, 8'h07, 8'h78, 8'h3f, 8'h3f, 8'hff,
        8'h0f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h01, 8'h02, 8'h00};
    localparam logic [7:0] ACT_REG_RST [ACT_NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    localparam int S_CORE_SRC = 0;
    localparam int S_CONV_OVS = 1;
    localparam int S_PUMP_SRC = 2;
    localparam int S_PIN_CC = 3;
    localparam int S_PIN_PO = 4;
    localparam int S_PIN_REF = 5;
    localparam int S_PLL_P = 6;
    localparam int S_PLL_J = 7;
    localparam int S_PLL_DH = 8;
    localparam int S_PLL_DL = 9;
    localparam int S_PLL_R = 10;
    localparam int S_DIV0 = 11;
    localparam int S_PLL_CTL = 16;
    localparam int S_AUTO_CTL = 17;
    localparam int S_STATUS = 18;
    localparam int POS_PLL_ON = 0;
    localparam int POS_AUTO_DIS = 1;
    localparam int POS_P = 3;
    localparam logic [2:0] PIN_ZERO_CODE = 3'h3;
    localparam logic [2:0] PIN_TWO_CODE = 3'h5;
    localparam logic [2:0] SRC_MUTE_IDX = 3'h7;
    localparam logic [2:0] CONV_LAST_CODE = 3'h5;
    // Settings used while auto-set mode runs; plain defaults.
    localparam logic [3:0] AUTO_P_CODE = 4'h0;
    localparam logic [5:0] AUTO_J = 6'h08;
    localparam logic [13:0] AUTO_D = 14'h0000;
    localparam logic [3:0] AUTO_R_CODE = 4'h0;
    localparam logic [6:0] AUTO_RATIO [4] = '{7'h01, 7'h03, 7'h07, 7'h01};
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- testbench/act_clock_tree_tb.sv ----
// Self-checking testbench of the audio clock tree configuration block.
`timescale 1ns/100ps
`default_nettype none
module act_clock_tree_tb
    import act_pkg::*;
;
logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, master_present;
logic [8:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata, tick, seed;
logic [3:0] s_axi_wstrb;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pll_enable;
logic core_clk, converter_clk, pump_clk, oversample_clk, pll_ref_pin_clk;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [4:0] pll_p, pll_r;
logic [5:0] pll_j, src_v;
logic [13:0] pll_d;
logic [7:0] sh [128];
int fail_count, n_tests;
wire logic [4:0] outs = {pll_ref_pin_clk, oversample_clk, pump_clk, converter_clk, core_clk};
// Source periods in aclk cycles: PLL, oscillator, master pin, bit clock, pin zero, pin two.
localparam int SRC_PER [6] = '{4, 6, 8, 10, 12, 14};
localparam logic [6:0] SRC_R [4] = '{7'h0d, 7'h0e, 7'h0f, 7'h0e};
localparam logic [6:0] PIN_R [4] = '{7'h10, 7'h10, 7'h11, 7'h11};
localparam logic [6:0] RAT_R [4] = '{7'h1b, 7'h1c, 7'h1d, 7'h1e};
localparam int SRC_S [4] = '{0, 4, 0, 0};
localparam int PIN_S [4] = '{4, 0, 4, 0};
act_clock_tree i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pll_clk(src_v[0]), .internal_oscillator(src_v[1]), .master_clock_pin(src_v[2]), .bit_clock(src_v[3]),
    .general_pin_zero(src_v[4]), .general_pin_two(src_v[5]), .master_present, .core_clk, .converter_clk,
    .pump_clk, .oversample_clk, .pll_ref_pin_clk, .pll_p, .pll_j, .pll_d, .pll_r, .pll_enable);
initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
end
// Sources are kept well below aclk/2 because the block samples them synchronously.
always @(posedge aclk) begin
    tick <= tick + 1;
    for (int k = 0; k < 6; k++) src_v[k] <= (tick % SRC_PER[k]) < SRC_PER[k] / 2;
end
function automatic int rnd(input int m);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return int'(seed[15:0]) % m;
endfunction
function automatic int pin(input int c);
    return c == 3 ? SRC_PER[4] : c == 5 ? SRC_PER[5] : 0;
endfunction
// Expected output period of divider d, zero when muted.
function automatic int exp_per(input int d);
    int c, i, s;
    if (d == 4) return pin(sh[7'h12] & 7);
    c = (sh[SRC_R[d]] >> SRC_S[d]) & 7;
    i = (d < 2) ? ((c <= 5) ? c + 1 : 7) : c;
    case (i)
        0: s = exp_per(1);
        1: s = master_present ? (sh[4][0] ? SRC_PER[0] : SRC_PER[2]) : SRC_PER[1];
        2: s = sh[4][0] ? SRC_PER[0] : SRC_PER[2];
        6: s = pin((sh[PIN_R[d]] >> PIN_S[d]) & 7);
        7: s = 0;
        default: s = SRC_PER[i - 2];
    endcase
    return s * ((sh[7'h25][1] ? sh[RAT_R[d]][6:0] : AUTO_RATIO[d]) + 1);
endfunction
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
        fail_count++;
        $display("Error %s expected %h seen %h", nm, e, g);
    end
endtask
// Skips the first period after a change, since a mid-period change may stretch it.
task automatic chk_per(input int d);
    int e, p, n, k;
    logic pv;
    #1;
    e = exp_per(d);
    p = 0;
    n = 0;
    k = 0;
    pv = outs[d];
    while (k < 3 && n < 4 * e + 200) begin
        @(posedge aclk);
        #1;
        n++;
        if (outs[d] === 1'b1 && pv === 1'b0) begin
            k++;
            if (k == 2) p = n;
            if (k == 3) p = n - p;
        end
        pv = outs[d];
    end
    if (e == 0) p = k;
    n_tests++;
    if (p != e) begin
        fail_count++;
        $display("Error period of clock %0d expected %0d seen %0d", d, e, p);
    end
endtask
task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [3:0] st, output logic [1:0] r);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
        @(posedge aclk);
        n++;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) fail_count++;
endtask
task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
        @(posedge aclk);
        n++;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) fail_count++;
endtask
task automatic w(input logic [6:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, 4'hf, r);
    sh[a] = d;
    chk("write response", 32'(RESP_OKAY), 32'(r));
endtask
task automatic setf(input logic [6:0] a, input int s, input logic [7:0] v);
    w(a, (sh[a] & ~(8'h7 << s)) | (v << s));
endtask
task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("read data", {24'h0, e}, d);
    chk("read response", 32'(RESP_OKAY), 32'(r));
endtask
task automatic chk_pll(input int p, input int j, input int d, input int r);
    repeat (2) @(posedge aclk);
    #1;
    chk("pll_p", p, 32'(pll_p));
    chk("pll_j", j, 32'(pll_j));
    chk("pll_d", d, 32'(pll_d));
    chk("pll_r", r, 32'(pll_r));
endtask
task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
initial begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    summarize;
end
initial begin
    logic [7:0] d;
    logic [31:0] rv;
    logic [1:0] r;
    int p, j, dd, rr;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    master_present = 1'b1;
    seed = 32'd66654;
    tick = '0;
    fail_count = 0;
    n_tests = 0;
    foreach (sh[i]) sh[i] = 8'h0;
    sh[4] = 8'h01;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk_pll(AUTO_P_CODE + 1, AUTO_J, AUTO_D, AUTO_R_CODE + 1);
    chk("pll_enable", 32'h1, 32'(pll_enable));
    for (int i = 0; i < S_STATUS; i++) rchk(ACT_REG_IDX[i], ACT_REG_RST[i]);
    for (int i = 0; i < S_STATUS; i++) begin
        d = 8'(rnd(256));
        // Random fill still obeys the forbidden P, J and D codes.
        if (i == S_PLL_P && d[6:3] == 4'hf) d[6] = 1'b0;
        if (i == S_PLL_J && d[5:0] == 6'h00) d[0] = 1'b1;
        if (i == S_PLL_DH) d[5] = 1'b0;
        w(ACT_REG_IDX[i], d);
        rchk(ACT_REG_IDX[i], d & ACT_REG_MASK[i]);
        sh[ACT_REG_IDX[i]] = d & ACT_REG_MASK[i];
    end
    wr(7'h01, 8'h5a, 4'hf, r);
    chk("unmapped write response", 32'(RESP_SLVERR), 32'(r));
    rd(7'h01, rv, r);
    chk("unmapped read data", 32'h0, rv);
    chk("unmapped read response", 32'(RESP_SLVERR), 32'(r));
    wr(7'h1b, 8'h55, 4'h0, r);
    chk("masked write response", 32'(RESP_OKAY), 32'(r));
    rchk(7'h1b, sh[7'h1b]);
    w(7'h25, 8'h02);
    for (int k = 0; k < 4; k++) begin
        // Software keeps P below 1111, J above zero and D at most 9999.
        p = k == 0 ? 14 : k == 1 ? 0 : rnd(15);
        j = k == 0 ? 63 : k == 1 ? 1 : rnd(63) + 1;
        dd = k == 0 ? 9999 : k == 1 ? 0 : rnd(10000);
        rr = k == 0 ? 15 : k == 1 ? 0 : rnd(16);
        w(7'h14, 8'(p << 3));
        w(7'h15, 8'(j));
        w(7'h16, 8'(dd >> 8));
        w(7'h17, 8'(dd));
        w(7'h18, 8'(rr));
        chk_pll(p + 1, j, dd, rr + 1);
    end
    w(7'h25, 8'h00);
    chk_pll(AUTO_P_CODE + 1, AUTO_J, AUTO_D, AUTO_R_CODE + 1);
    w(7'h25, 8'h02);
    w(7'h04, 8'h01);
    // Clock settings change only while no audio traffic runs in this bench.
    for (int dv = 0; dv < 4; dv++) begin
        if (dv == 2) setf(7'h0e, 4, 8'h1);
        for (int c = 0; c < 8; c++) begin
            setf(SRC_R[dv], SRC_S[dv], 8'(c));
            setf(PIN_R[dv], PIN_S[dv], 8'(c == 5 ? 5 : rnd(3) == 0 ? 1 : rnd(2) == 0 ? 3 : 5));
            w(RAT_R[dv], 8'((dv == 0 && c == 4) ? 127 : (c % 2 == 1 || (dv == 3 && c == 0)) ? 0 : rnd(8)));
            chk_per(dv);
        end
    end
    for (int c = 1; c < 6; c += 2) begin
        setf(7'h12, 0, 8'(c));
        chk_per(4);
    end
    w(7'h1b, 8'h01);
    for (int k = 0; k < 4; k++) begin
        w(7'h04, 8'(k[1]));
        master_present <= k[0];
        setf(7'h0d, 0, 8'h0);
        chk_per(0);
        chk_per(1);
        chk("pll_enable", 32'(k[1]), 32'(pll_enable));
        setf(7'h0d, 0, 8'h1);
        chk_per(0);
        rchk(7'h40, {3'h0, !k[0], 4'hc});
    end
    setf(7'h0f, 0, 8'h3);
    setf(7'h0e, 0, 8'h2);
    w(7'h25, 8'h00);
    for (int dv = 0; dv < 4; dv++) chk_per(dv);
    summarize;
end
endmodule
`default_nettype wire
